// >>> core/line_irq_pkg.sv
// Operation
// RL1 - driver fault flag sets on rising level, or either edge when its select is one
// RL2 - signal loss flag sets on rising level, or either edge when its select is one
// RL3 - status flags clear only when software writes one to their bit
// RL4 - template overflow flag sets when a multi-interval template sum exceeds plus-minus 63
// RL5 - transmit jitter buffer slip sets bit 5 of second status register
// RL6 - receive jitter buffer slip sets bit 4 of second status register
// RL7 - excess zero error sets bit 2 of second status register
// RL8 - bipolar or HDB3 code violation sets bit 1 of second status register
// RL9 - wrap of the 16-bit excess zero counter sets bit 0
// RL10 - counter read as high byte at 03C, low byte at 03D, reset zero
// RL11 - one line front end bit shows any pending line interface flag
// RL12 - bits 5..0 at 040 show framing side block pending interrupts
// RL13 - bits 7..0 at 041 show link layer, elastic store, system side pending
// RL14 - second link registers sit at same offset plus 100
// RL15 - interrupt output only reflects flags whose enable bit is one
// RL16 - driver fault level reads one while a driver failure is present
// RL17 - an event in the same cycle as its clear keeps the flag set
// RL18 - indication bits are the plain OR of their source flags
package line_irq_pkg;

   localparam int ADDR_W   = 9;
   localparam int DATA_W   = 8;
   localparam int CNT_W    = 16;
   localparam int LINKS    = 2;

   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] data_t;

   // ---------------------------------------------------------------
   // register offsets, low byte; bit 8 of the address picks the link
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_ENABLE_A        = 8'h33;
   localparam logic [7:0] OFS_ENABLE_B        = 8'h34;
   localparam logic [7:0] OFS_EDGE_SEL        = 8'h35;
   localparam logic [7:0] OFS_LINE_LEVEL      = 8'h36;
   localparam logic [7:0] OFS_EVENT_STATUS_A  = 8'h3A;
   localparam logic [7:0] OFS_EVENT_STATUS_B  = 8'h3B;
   localparam logic [7:0] OFS_COUNT_HIGH      = 8'h3C;
   localparam logic [7:0] OFS_COUNT_LOW       = 8'h3D;
   localparam logic [7:0] OFS_LINE_SOURCE     = 8'h3F;
   localparam logic [7:0] OFS_FRAMING_SOURCE  = 8'h40;
   localparam logic [7:0] OFS_LINK_SOURCE     = 8'h41;
   localparam int         LINK_SEL_BIT        = 8;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int DRIVER_FAULT_BIT        = 2;
   localparam int SIGNAL_LOSS_BIT         = 0;
   localparam int TEMPLATE_OVERFLOW_BIT   = 6;
   localparam int TX_JITTER_BUF_SLIP_BIT  = 5;
   localparam int RX_JITTER_BUF_SLIP_BIT  = 4;
   localparam int EXCESS_ZERO_BIT         = 2;
   localparam int CODE_VIOLATION_BIT      = 1;
   localparam int ERROR_COUNTER_WRAP_BIT  = 0;
   localparam int LINE_FRONT_END_BIT      = 0;

   localparam data_t MASK_A = 8'h05;
   localparam data_t MASK_B = 8'h77;

   localparam data_t RST_REG = 8'h00;
   localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
   localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;

endpackage : line_irq_pkg

// >>> core/link_if.sv
`timescale 1ns/1ns
interface link_if;
   logic        df_lvl;
   logic        los_lvl;
   logic        df_sel;
   logic        los_sel;
   logic        tmpl_ovf;
   logic        tx_slip;
   logic        rx_slip;
   logic        zero_err;
   logic        cv;
   logic        clr_a;
   logic        clr_b;
   logic [7:0]  wdata;
   logic [7:0]  status_a;
   logic [7:0]  status_b;
   logic [15:0] count;

   modport core (input df_lvl, los_lvl, df_sel, los_sel, tmpl_ovf, tx_slip, rx_slip,
                 zero_err, cv, clr_a, clr_b, wdata, output status_a, status_b, count);
   modport ctrl (output df_lvl, los_lvl, df_sel, los_sel, tmpl_ovf, tx_slip, rx_slip,
                 zero_err, cv, clr_a, clr_b, wdata, input status_a, status_b, count);
endinterface : link_if

// >>> core/sync2.sv
`timescale 1ns/1ns
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

   assign q = q_r;
endmodule : sync2

// >>> core/link_event_core.sv
`timescale 1ns/1ns
module link_event_core (
   input  wire logic clk_sys,
   input  wire logic rst_sync_n,
   link_if.core      lif
);
   import line_irq_pkg::*;

   data_t             flags_a_r;
   data_t             flags_a_nxt;
   data_t             flags_b_r;
   data_t             flags_b_nxt;
   logic [CNT_W-1:0]  count_r;
   logic [CNT_W-1:0]  count_nxt;
   logic              df_prev_r;
   logic              los_prev_r;
   data_t             set_a;
   data_t             set_b;
   data_t             clr_a;
   data_t             clr_b;
   logic              wrap;

   // ---------------------------------------------------------------
   // event capture
   // ---------------------------------------------------------------
   always_comb begin
      set_a = '0;
      set_b = '0;
      set_a[DRIVER_FAULT_BIT] = (lif.df_lvl & ~df_prev_r) |
                                (lif.df_sel & ~lif.df_lvl & df_prev_r);       // [RL1]
      set_a[SIGNAL_LOSS_BIT]  = (lif.los_lvl & ~los_prev_r) |
                                (lif.los_sel & ~lif.los_lvl & los_prev_r);    // [RL2]
      set_b[TEMPLATE_OVERFLOW_BIT]  = lif.tmpl_ovf;                          // [RL4]
      set_b[TX_JITTER_BUF_SLIP_BIT] = lif.tx_slip;                           // [RL5]
      set_b[RX_JITTER_BUF_SLIP_BIT] = lif.rx_slip;                           // [RL6]
      set_b[EXCESS_ZERO_BIT]        = lif.zero_err;                          // [RL7]
      set_b[CODE_VIOLATION_BIT]     = lif.cv;                                // [RL8]
      // counter wraps silently; only the flag records it
      wrap      = lif.zero_err && (count_r == COUNT_MAX);
      count_nxt = lif.zero_err ? count_r + 16'h0001 : count_r;               // [RL10]
      set_b[ERROR_COUNTER_WRAP_BIT] = wrap;                                  // [RL9]
      clr_a = lif.clr_a ? (lif.wdata & MASK_A) : '0;                         // [RL3]
      clr_b = lif.clr_b ? (lif.wdata & MASK_B) : '0;                         // [RL3]
      // set applied after clear so a coincident event survives
      flags_a_nxt = (flags_a_r & ~clr_a) | set_a;                            // [RL17]
      flags_b_nxt = (flags_b_r & ~clr_b) | set_b;                            // [RL17]
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         flags_a_r  <= RST_REG;
         flags_b_r  <= RST_REG;
         count_r    <= RST_COUNT;
         df_prev_r  <= 1'b0;
         los_prev_r <= 1'b0;
      end else begin
         flags_a_r  <= flags_a_nxt;
         flags_b_r  <= flags_b_nxt;
         count_r    <= count_nxt;
         df_prev_r  <= lif.df_lvl;
         los_prev_r <= lif.los_lvl;
      end
   end

   assign lif.status_a = flags_a_r;
   assign lif.status_b = flags_b_r;
   assign lif.count    = count_r;
endmodule : link_event_core

// >>> core/line_irq_top.sv
`timescale 1ns/1ns
module line_irq_top (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_n,
   input  wire line_irq_pkg::addr_t           reg_addr,
   input  wire line_irq_pkg::data_t           reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output      line_irq_pkg::data_t           reg_rdata,
   input  wire logic [1:0]                    driver_fault_level,
   input  wire logic [1:0]                    signal_loss_level,
   input  wire logic [1:0]                    template_sum_over,
   input  wire logic [1:0]                    tx_ja_fifo_slip,
   input  wire logic [1:0]                    rx_ja_fifo_slip,
   input  wire logic [1:0]                    excess_zero,
   input  wire logic [1:0]                    bipolar_violation,
   input  wire logic [1:0]                    hdb3_violation,
   input  wire logic [1:0][5:0]               framing_pending,
   input  wire logic [1:0][7:0]               link_layer_pending,
   output      logic                          irq
);
   import line_irq_pkg::*;

   // ---------------------------------------------------------------
   // reset release and level synchronisers
   // ---------------------------------------------------------------
   logic       rst_sync_n;
   logic [1:0] df_sync;
   logic [1:0] los_sync;

   sync2 #(.W(1)) u_rst_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (1'b1),
      .q       (rst_sync_n)
   );

   // fault levels come from analog front end, asynchronous to clk_sys
   sync2 #(.W(2)) u_df_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_sync_n),
      .d       (driver_fault_level),
      .q       (df_sync)
   );

   sync2 #(.W(2)) u_los_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_sync_n),
      .d       (signal_loss_level),
      .q       (los_sync)
   );

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   logic       link_sel;
   logic [7:0] low_ofs;

   assign link_sel = reg_addr[LINK_SEL_BIT];                                 // [RL14]
   assign low_ofs  = reg_addr[7:0];

   // ---------------------------------------------------------------
   // control registers, one set per link
   // ---------------------------------------------------------------
   data_t en_a_r   [LINKS];
   data_t en_a_nxt [LINKS];
   data_t en_b_r   [LINKS];
   data_t en_b_nxt [LINKS];
   data_t sel_r    [LINKS];
   data_t sel_nxt  [LINKS];

   always_comb begin
      for (int i = 0; i < LINKS; i++) begin
         en_a_nxt[i] = en_a_r[i];
         en_b_nxt[i] = en_b_r[i];
         sel_nxt[i]  = sel_r[i];
         if (reg_wr && (link_sel == i[0])) begin
            if (low_ofs == OFS_ENABLE_A) begin
               en_a_nxt[i] = reg_wdata & MASK_A;
            end
            if (low_ofs == OFS_ENABLE_B) begin
               en_b_nxt[i] = reg_wdata & MASK_B;
            end
            if (low_ofs == OFS_EDGE_SEL) begin
               sel_nxt[i] = reg_wdata & MASK_A;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int i = 0; i < LINKS; i++) begin
            en_a_r[i] <= RST_REG;
            en_b_r[i] <= RST_REG;
            sel_r[i]  <= RST_REG;
         end
      end else begin
         for (int i = 0; i < LINKS; i++) begin
            en_a_r[i] <= en_a_nxt[i];
            en_b_r[i] <= en_b_nxt[i];
            sel_r[i]  <= sel_nxt[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // per-link event cores
   // ---------------------------------------------------------------
   data_t            stat_a [LINKS];
   data_t            stat_b [LINKS];
   logic [CNT_W-1:0] count  [LINKS];

   for (genvar g = 0; g < LINKS; g++) begin : gen_link
      link_if lif ();

      assign lif.df_lvl   = df_sync[g];
      assign lif.los_lvl  = los_sync[g];
      assign lif.df_sel   = sel_r[g][DRIVER_FAULT_BIT];
      assign lif.los_sel  = sel_r[g][SIGNAL_LOSS_BIT];
      assign lif.tmpl_ovf = template_sum_over[g];
      assign lif.tx_slip  = tx_ja_fifo_slip[g];
      assign lif.rx_slip  = rx_ja_fifo_slip[g];
      assign lif.zero_err = excess_zero[g];
      assign lif.cv       = bipolar_violation[g] | hdb3_violation[g];       // [RL8]
      assign lif.clr_a    = reg_wr && (link_sel == g) && (low_ofs == OFS_EVENT_STATUS_A);
      assign lif.clr_b    = reg_wr && (link_sel == g) && (low_ofs == OFS_EVENT_STATUS_B);
      assign lif.wdata    = reg_wdata;

      link_event_core u_core (
         .clk_sys    (clk_sys),
         .rst_sync_n (rst_sync_n),
         .lif        (lif)
      );

      assign stat_a[g] = lif.status_a;
      assign stat_b[g] = lif.status_b;
      assign count[g]  = lif.count;
   end

   // ---------------------------------------------------------------
   // source indication
   // ---------------------------------------------------------------
   logic [LINKS-1:0] line_front_end_pending;

   always_comb begin
      for (int i = 0; i < LINKS; i++) begin
         line_front_end_pending[i] = |{stat_a[i], stat_b[i]};                // [RL11] [RL18]
      end
   end

   // ---------------------------------------------------------------
   // read path, data one cycle after the strobe
   // ---------------------------------------------------------------
   data_t rdata_r;
   data_t rdata_nxt;
   data_t level_word;
   int    li;

   always_comb begin
      li         = link_sel ? 1 : 0;
      level_word = '0;
      level_word[DRIVER_FAULT_BIT] = df_sync[li];                            // [RL16]
      level_word[SIGNAL_LOSS_BIT]  = los_sync[li];
      rdata_nxt = '0;
      if (reg_rd) begin
         unique case (low_ofs)
            OFS_ENABLE_A:       rdata_nxt = en_a_r[li];
            OFS_ENABLE_B:       rdata_nxt = en_b_r[li];
            OFS_EDGE_SEL:       rdata_nxt = sel_r[li];
            OFS_LINE_LEVEL:     rdata_nxt = level_word;
            OFS_EVENT_STATUS_A: rdata_nxt = stat_a[li];
            OFS_EVENT_STATUS_B: rdata_nxt = stat_b[li];
            OFS_COUNT_HIGH:     rdata_nxt = count[li][15:8];                 // [RL10]
            OFS_COUNT_LOW:      rdata_nxt = count[li][7:0];                  // [RL10]
            OFS_LINE_SOURCE:    rdata_nxt = {7'h00, line_front_end_pending[li]}; // [RL11]
            OFS_FRAMING_SOURCE: rdata_nxt = {2'h0, framing_pending[li]};     // [RL12] [RL18]
            OFS_LINK_SOURCE:    rdata_nxt = link_layer_pending[li];          // [RL13] [RL18]
            default:            rdata_nxt = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // interrupt output
   // ---------------------------------------------------------------
   logic irq_r;
   logic irq_nxt;

   always_comb begin
      irq_nxt = 1'b0;
      for (int i = 0; i < LINKS; i++) begin
         irq_nxt = irq_nxt | (|(stat_a[i] & en_a_r[i])) | (|(stat_b[i] & en_b_r[i])); // [RL15]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_r <= RST_REG;
         irq_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         irq_r   <= irq_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq       = irq_r;
endmodule : line_irq_top

// >>> sim/line_irq_assertions.sv
`timescale 1ns/1ns
module line_irq_assertions (
   input wire logic                clk_sys,
   input wire logic                rst_n,
   input wire line_irq_pkg::addr_t reg_addr,
   input wire line_irq_pkg::data_t reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire line_irq_pkg::data_t reg_rdata,
   input wire logic [1:0]          driver_fault_level,
   input wire logic [1:0]          signal_loss_level,
   input wire logic [1:0]          template_sum_over,
   input wire logic [1:0]          tx_ja_fifo_slip,
   input wire logic [1:0]          rx_ja_fifo_slip,
   input wire logic [1:0]          excess_zero,
   input wire logic [1:0]          bipolar_violation,
   input wire logic [1:0]          hdb3_violation,
   input wire logic [1:0][5:0]     framing_pending,
   input wire logic [1:0][7:0]     link_layer_pending,
   input wire logic                irq
);
   import line_irq_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ---------------------------------------------------------------
   // read-back sequences
   // ---------------------------------------------------------------
   sequence rd_lo(ofs);
      reg_rd && reg_addr[7:0] == ofs;
   endsequence
   // one quiet cycle between event and read, with no clear write in it
   sequence slip_then_read;
      tx_ja_fifo_slip[0] ##1 !reg_wr ##1 (reg_rd && reg_addr == 9'h03B);
   endsequence
   sequence zero_then_read;
      excess_zero[1] ##1 !reg_wr ##1 (reg_rd && reg_addr == 9'h13B);
   endsequence
   sequence viol_then_read;
      (bipolar_violation[0] || hdb3_violation[0]) ##1 !reg_wr ##1
         (reg_rd && reg_addr == 9'h03B);
   endsequence
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   a_status_a_rsv: assert property (rd_lo(8'h3A) |=> (reg_rdata & 8'hFA) == 8'h00)
      else $error("reserved status a bits set");
   a_status_b_rsv: assert property (rd_lo(8'h3B) |=> (reg_rdata & 8'h88) == 8'h00)
      else $error("reserved status b bits set");
   a_line_src_rsv: assert property (rd_lo(8'h3F) |=> reg_rdata[7:1] == 7'h00)
      else $error("line source upper bits set");
   a_framing_src: assert property (rd_lo(8'h40) |=>
      reg_rdata == {2'b00, $past(framing_pending[reg_addr[8]])})
      else $error("framing source mismatch");
   a_link_src: assert property (rd_lo(8'h41) |=>
      reg_rdata == $past(link_layer_pending[reg_addr[8]]))
      else $error("link source mismatch");
   a_tx_slip_seen: assert property (slip_then_read |=> reg_rdata[5])
      else $error("tx slip flag missing");
   a_zero_err_two: assert property (zero_then_read |=> reg_rdata[2])
      else $error("excess zero flag missing");
   a_viol_seen: assert property (viol_then_read |=> reg_rdata[1])
      else $error("code violation flag missing");
endmodule : line_irq_assertions

bind line_irq_top line_irq_assertions u_chk (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .driver_fault_level, .signal_loss_level,
   .template_sum_over, .tx_ja_fifo_slip, .rx_ja_fifo_slip, .excess_zero,
   .bipolar_violation, .hdb3_violation, .framing_pending, .link_layer_pending, .irq);

// >>> sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import line_irq_pkg::*;
   logic            clk_sys = 1'b0;
   logic            rst_n = 1'b0;
   addr_t           reg_addr = '0;
   data_t           reg_wdata = '0;
   logic            reg_wr = 1'b0;
   logic            reg_rd = 1'b0;
   data_t           reg_rdata;
   logic [1:0]      df_l = '0, los_l = '0, tmpl = '0, txs = '0, rxs = '0;
   logic [1:0]      zer = '0, bip = '0, cvh = '0;
   logic [1:0][5:0] frm = '0;
   logic [1:0][7:0] lnk = '0;
   logic            irq;
   int              errors = 0;
   int              n_checks = 0;
   always #5 clk_sys = ~clk_sys;
   line_irq_top u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .driver_fault_level(df_l), .signal_loss_level(los_l),
      .template_sum_over(tmpl), .tx_ja_fifo_slip(txs), .rx_ja_fifo_slip(rxs),
      .excess_zero(zer), .bipolar_violation(bip), .hdb3_violation(cvh),
      .framing_pending(frm), .link_layer_pending(lnk), .irq);
   // ---------------------------------------------------------------
   // bus and check helpers
   // ---------------------------------------------------------------
   task automatic chk(string what, data_t exp, data_t got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wr(addr_t a, data_t v);
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   // data stands only in the cycle after the strobe
   task automatic rd(addr_t a, string what, data_t exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask : rd
   task automatic setlvl(int ln, int b, logic v);
      @(posedge clk_sys);
      if (b == 2) df_l[ln] <= v; else los_l[ln] <= v;
      cyc(5);
   endtask : setlvl
   task automatic fire(int ln, int k, logic v);
      case (k)
         0: tmpl[ln] <= v;
         1: txs[ln] <= v;
         2: rxs[ln] <= v;
         3: zer[ln] <= v;
         4: bip[ln] <= v;
         default: cvh[ln] <= v;
      endcase
   endtask : fire
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      addr_t ofs [15] = '{9'h03A, 9'h03B, 9'h03C, 9'h03D, 9'h03F, 9'h040, 9'h041, 9'h033,
                          9'h034, 9'h035, 9'h036, 9'h13A, 9'h13B, 9'h13C, 9'h13D};
      foreach (ofs[i]) rd(ofs[i], "reset value", 8'h00);
      $display("done reset values");
   endtask : t_reset
   task automatic t_edge(int ln, int b);
      addr_t base = addr_t'(ln << 8);
      data_t m = data_t'(1 << b);
      setlvl(ln, b, 1'b1);
      rd(base + 9'h036, "level", m);
      rd(base + 9'h03A, "rise flag", m);
      wr(base + 9'h03A, ~m);
      rd(base + 9'h03A, "flag after zero write", m);
      wr(base + 9'h03A, m);
      setlvl(ln, b, 1'b0);
      rd(base + 9'h03A, "fall ignored", 8'h00);
      wr(base + 9'h035, m);
      setlvl(ln, b, 1'b1);
      wr(base + 9'h03A, m);
      setlvl(ln, b, 1'b0);
      rd(base + 9'h03A, "fall flag", m);
      wr(base + 9'h03A, m);
      wr(base + 9'h035, 8'h00);
      $display("done edge link %0d bit %0d", ln, b);
   endtask : t_edge
   task automatic t_events(int ln);
      addr_t base = addr_t'(ln << 8);
      data_t bits [6] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h02};
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_sys);
         fire(ln, k, 1'b1);
         @(posedge clk_sys);
         fire(ln, k, 1'b0);
         rd(base + 9'h03B, "event flag", bits[k]);
         rd(base + 9'h03F, "line pending", 8'h01);
         wr(base + 9'h03B, bits[k]);
         rd(base + 9'h03F, "line pending gone", 8'h00);
      end
      rd(base + 9'h03D, "count low", 8'h01);
      $display("done events link %0d", ln);
   endtask : t_events
   task automatic t_irq;
      wr(9'h134, 8'h20);
      @(posedge clk_sys);
      txs[1] <= 1'b1;
      @(posedge clk_sys);
      txs[1] <= 1'b0;
      cyc(2);
      #1 chk("irq enabled", 8'h01, {7'h00, irq});
      wr(9'h134, 8'h00);
      cyc(2);
      #1 chk("irq masked", 8'h00, {7'h00, irq});
      rd(9'h13B, "masked flag visible", 8'h20);
      wr(9'h13B, 8'h20);
      // clear and event land on the same edge
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= 9'h03B; reg_wdata <= 8'h10; rxs[0] <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0; rxs[0] <= 1'b0;
      rd(9'h03B, "set over clear", 8'h10);
      wr(9'h03B, 8'h10);
      $display("done irq");
   endtask : t_irq
   task automatic t_wrap;
      @(posedge clk_sys);
      zer[0] <= 1'b1;
      cyc(65534);
      zer[0] <= 1'b0;
      rd(9'h03C, "count high", 8'hFF);
      rd(9'h03D, "count low", 8'hFF);
      wr(9'h03B, 8'h04);
      fire(0, 3, 1'b1);
      @(posedge clk_sys);
      fire(0, 3, 1'b0);
      rd(9'h03B, "wrap flag", 8'h05);
      wr(9'h03C, 8'hFF);
      rd(9'h03C, "count high wrapped", 8'h00);
      wr(9'h03B, 8'h05);
      $display("done wrap");
   endtask : t_wrap
   task automatic t_ind;
      data_t p [2] = '{8'h2A, 8'h15};
      foreach (p[i]) begin
         @(posedge clk_sys);
         frm[0] <= p[i][5:0];
         lnk[1] <= {p[i][5:0], 2'b10};
         rd(9'h040, "framing source", p[i]);
         rd(9'h140, "framing source two", 8'h00);
         rd(9'h141, "link source", {p[i][5:0], 2'b10});
      end
      rd(9'h050, "unmapped", 8'h00);
      $display("done indication");
   endtask : t_ind
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   // about a third over the expected run, dominated by the counter wrap
   initial begin
      #900_000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      cyc(3);
      t_reset();
      t_edge(0, 2);
      t_edge(1, 0);
      t_events(0);
      t_events(1);
      t_irq();
      t_wrap();
      t_ind();
      wrap_up();
   end
endmodule : testbench
